// *** verilog/rssx_pkg.sv ***
package rssx_pkg;

	// Operation codes presented by the decoder
	typedef enum logic [2:0]
	{
		RSSX_OP_NONE,
		RSSX_OP_ROTATE_RIGHT,
		RSSX_OP_LIT_MINUS_ACC,
		RSSX_OP_REG_MINUS_ACC,
		RSSX_OP_NIBBLE_EXCHANGE,
		RSSX_OP_REG_XOR,
		RSSX_OP_LIT_XOR
	} rssx_op_t;

	localparam int unsigned RSSX_DATA_W = 8;
	localparam int unsigned RSSX_ADDR_W = 7;

	// Target select encoding
	localparam logic RSSX_TGT_ACC = 1'b0;
	localparam logic RSSX_TGT_REG = 1'b1;

	// Register map (byte addresses)
	localparam logic [11:0] RSSX_CTRL_OFS   = 12'h000;
	localparam logic [11:0] RSSX_OPER_OFS   = 12'h004;
	localparam logic [11:0] RSSX_ACC_OFS    = 12'h008;
	localparam logic [11:0] RSSX_FLAGS_OFS  = 12'h00c;
	localparam logic [11:0] RSSX_RESULT_OFS = 12'h010;

	// Control word fields
	localparam int unsigned RSSX_CTRL_OP_LSB  = 0;
	localparam int unsigned RSSX_CTRL_TGT_BIT = 4;
	localparam int unsigned RSSX_CTRL_ADR_LSB = 8;

	// Flag fields
	localparam int unsigned RSSX_FLAG_C_BIT  = 0;
	localparam int unsigned RSSX_FLAG_DC_BIT = 1;
	localparam int unsigned RSSX_FLAG_Z_BIT  = 2;

	localparam logic [7:0] RSSX_ACC_RST   = 8'h00;
	localparam logic [2:0] RSSX_FLAGS_RST = 3'h0;

	localparam logic [1:0] RSSX_RESP_OKAY   = 2'h0;
	localparam logic [1:0] RSSX_RESP_SLVERR = 2'h2;

endpackage

// *** verilog/rssx_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module rssx_core
	import rssx_pkg::*;
(
	input  wire logic [2:0] op,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] operand,
	input  wire logic [7:0] literal,
	input  wire logic       carry_in,
	input  wire logic       nibble_carry_in,
	input  wire logic       zero_in,
	output logic      [7:0] result,
	output logic            carry_out,
	output logic            nibble_carry_out,
	output logic            zero_out,
	output logic            to_register
);
	logic [8:0] diff;
	logic [4:0] low_diff;
	logic [7:0] minuend;

	always_comb
	begin
		minuend = (rssx_op_t'(op) == RSSX_OP_LIT_MINUS_ACC) ? literal : operand;
		// Borrow-free means the 9-bit sum of minuend and ~acc + 1 carries out
		diff = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
		low_diff = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
		result = operand;
		carry_out = carry_in;
		nibble_carry_out = nibble_carry_in;
		zero_out = zero_in;
		to_register = 1'b1;
		case (rssx_op_t'(op))
			RSSX_OP_ROTATE_RIGHT:
			begin
				result = {carry_in, operand[7:1]};
				carry_out = operand[0];
			end
			RSSX_OP_LIT_MINUS_ACC, RSSX_OP_REG_MINUS_ACC:
			begin
				result = diff[7:0];
				carry_out = diff[8];
				nibble_carry_out = low_diff[4];
				zero_out = (diff[7:0] == 8'h00);
				to_register = (rssx_op_t'(op) == RSSX_OP_REG_MINUS_ACC);
			end
			RSSX_OP_NIBBLE_EXCHANGE:
				result = {operand[3:0], operand[7:4]};
			RSSX_OP_REG_XOR:
			begin
				result = acc ^ operand;
				zero_out = ((acc ^ operand) == 8'h00);
			end
			RSSX_OP_LIT_XOR:
			begin
				result = acc ^ literal;
				zero_out = ((acc ^ literal) == 8'h00);
				to_register = 1'b0;
			end
			default:
			begin
				// No operation hands the accumulator back unchanged
				result = acc;
				to_register = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// *** verilog/rssx_alu.sv ***
// What this block does
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Target select 0 writes accumulator, 1 writes the addressed register (7-bit address).
// - Literal minus accumulator into accumulator, updating carry, nibble carry, zero.
// - Register minus accumulator to selected target, updating carry, nibble carry, zero.
// - Nibble exchange of register to selected target, flags untouched.
// - Accumulator XOR register to selected target, only zero flag updated.
// - Accumulator XOR literal into accumulator, only zero flag updated.
`timescale 1ns/1ps
`default_nettype none
module rssx_alu
	import rssx_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  reg_rdata,
	output logic [6:0]       reg_addr,
	output logic [7:0]       reg_wdata,
	output logic             reg_we
);
	logic [2:0]  op_reg;
	logic        tgt_reg;
	logic [6:0]  adr_reg;
	logic [7:0]  literal_reg;
	logic [7:0]  acc_reg;
	logic        carry_reg;
	logic        nibble_carry_reg;
	logic        zero_reg;
	logic [7:0]  result_reg;
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        exec_pulse;
	logic        wr_fire;
	logic        wr_map;
	logic [7:0]  res;
	logic        c_n;
	logic        dc_n;
	logic        z_n;
	logic        to_reg;
	logic [7:0]  operand_hold;
	logic        aw_held_next;
	logic        w_held_next;
	logic        bvalid_next;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == RSSX_CTRL_OFS) || (a == RSSX_OPER_OFS) || (a == RSSX_ACC_OFS)
			|| (a == RSSX_FLAGS_OFS) || (a == RSSX_RESULT_OFS);
	endfunction

	rssx_core u_core
	(
		.op               (op_reg),
		.acc              (acc_reg),
		.operand          (operand_hold),
		.literal          (literal_reg),
		.carry_in         (carry_reg),
		.nibble_carry_in  (nibble_carry_reg),
		.zero_in          (zero_reg),
		.result           (res),
		.carry_out        (c_n),
		.nibble_carry_out (dc_n),
		.zero_out         (z_n),
		.to_register      (to_reg)
	);

	// Register operand is the file's read data, captured one cycle after the address settles
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			operand_hold <= 8'h00;
		else
			operand_hold <= reg_rdata;
	end

	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_map = mapped(aw_addr_reg);

	// Ready flops look one edge ahead so they drop as soon as a channel is taken
	always_comb
	begin
		aw_held_next = aw_held || (s_axi_awvalid && s_axi_awready);
		w_held_next = w_held || (s_axi_wvalid && s_axi_wready);
		bvalid_next = s_axi_bvalid && !s_axi_bready;
		if (wr_fire)
		begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RSSX_RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held_next && !bvalid_next;
			s_axi_wready <= !w_held_next && !bvalid_next;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? RSSX_RESP_OKAY : RSSX_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Writing the control word with byte 0 starts an operation two cycles later
	logic exec_arm;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			op_reg <= 3'h0;
			tgt_reg <= RSSX_TGT_ACC;
			adr_reg <= 7'h00;
			literal_reg <= 8'h00;
			exec_arm <= 1'b0;
			exec_pulse <= 1'b0;
		end
		else
		begin
			exec_pulse <= exec_arm;
			exec_arm <= 1'b0;
			if (wr_fire && aw_addr_reg == RSSX_CTRL_OFS)
			begin
				if (w_strb_reg[0])
				begin
					op_reg <= w_data_reg[RSSX_CTRL_OP_LSB +: 3];
					tgt_reg <= w_data_reg[RSSX_CTRL_TGT_BIT];
					exec_arm <= 1'b1;
				end
				if (w_strb_reg[1])
					adr_reg <= w_data_reg[RSSX_CTRL_ADR_LSB +: 7];
			end
			if (wr_fire && aw_addr_reg == RSSX_OPER_OFS && w_strb_reg[0])
				literal_reg <= w_data_reg[7:0];
		end
	end

	// Accumulator and flags: an executing operation wins over a software write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_reg <= RSSX_ACC_RST;
			{zero_reg, nibble_carry_reg, carry_reg} <= RSSX_FLAGS_RST;
			result_reg <= 8'h00;
		end
		else if (exec_pulse)
		begin
			result_reg <= res;
			carry_reg <= c_n;
			nibble_carry_reg <= dc_n;
			zero_reg <= z_n;
			if (!(to_reg && tgt_reg == RSSX_TGT_REG))
				acc_reg <= res;
		end
		else if (wr_fire && w_strb_reg[0])
		begin
			if (aw_addr_reg == RSSX_ACC_OFS)
				acc_reg <= w_data_reg[7:0];
			if (aw_addr_reg == RSSX_FLAGS_OFS)
			begin
				carry_reg <= w_data_reg[RSSX_FLAG_C_BIT];
				nibble_carry_reg <= w_data_reg[RSSX_FLAG_DC_BIT];
				zero_reg <= w_data_reg[RSSX_FLAG_Z_BIT];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reg_addr <= 7'h00;
			reg_wdata <= 8'h00;
			reg_we <= 1'b0;
		end
		else
		begin
			// Address follows the control write at once so the operand is read before execution
			if (wr_fire && aw_addr_reg == RSSX_CTRL_OFS && w_strb_reg[1])
				reg_addr <= w_data_reg[RSSX_CTRL_ADR_LSB +: 7];
			else
				reg_addr <= adr_reg;
			reg_we <= exec_pulse && to_reg && (tgt_reg == RSSX_TGT_REG);
			reg_wdata <= res;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RSSX_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped({s_axi_araddr[11:2], 2'b00}) ?
					RSSX_RESP_OKAY : RSSX_RESP_SLVERR;
				case ({s_axi_araddr[11:2], 2'b00})
					RSSX_CTRL_OFS:   s_axi_rdata <= {17'h0, adr_reg, 3'h0, tgt_reg, 1'b0, op_reg};
					RSSX_OPER_OFS:   s_axi_rdata <= {24'h0, literal_reg};
					RSSX_ACC_OFS:    s_axi_rdata <= {24'h0, acc_reg};
					RSSX_FLAGS_OFS:  s_axi_rdata <= {29'h0, zero_reg, nibble_carry_reg, carry_reg};
					RSSX_RESULT_OFS: s_axi_rdata <= {24'h0, result_reg};
					default:         s_axi_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	a_rot_carry: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_ROTATE_RIGHT
		|=> carry_reg == $past(operand_hold[0]) && result_reg == {$past(carry_reg), $past(operand_hold[7:1])})
		else $error("rotate carry wrong");
	a_target_reg: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && tgt_reg && rssx_op_t'(op_reg) == RSSX_OP_NIBBLE_EXCHANGE
		|=> reg_we && acc_reg == $past(acc_reg))
		else $error("register target not written");
	a_lit_sub: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_LIT_MINUS_ACC
		|=> acc_reg == 8'($past(literal_reg) - $past(acc_reg)) && !reg_we)
		else $error("literal subtract wrong");
	a_reg_sub_c: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_REG_MINUS_ACC
		|=> carry_reg == ($past(operand_hold) >= $past(acc_reg)))
		else $error("register subtract carry wrong");
	a_swap_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_NIBBLE_EXCHANGE
		|=> $stable({carry_reg, nibble_carry_reg, zero_reg}))
		else $error("swap changed flags");
	a_xor_carry: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_REG_XOR
		|=> $stable(carry_reg) && zero_reg == ($past(acc_reg) == $past(operand_hold)))
		else $error("register xor flags wrong");
	a_lit_xor: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_LIT_XOR
		|=> acc_reg == ($past(acc_reg) ^ $past(literal_reg)) && $stable(nibble_carry_reg))
		else $error("literal xor wrong");
	a_nib_borrow: assert property (@(posedge aclk) disable iff (!aresetn)
		exec_pulse && rssx_op_t'(op_reg) == RSSX_OP_LIT_MINUS_ACC
		|=> nibble_carry_reg == ($past(literal_reg[3:0]) >= $past(acc_reg[3:0])))
		else $error("nibble carry wrong");
endmodule
`default_nettype wire

// *** dv/rssx_regfile_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rssx_regfile_model
(
	input  wire logic       clk,
	input  wire logic [6:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       we,
	output logic      [7:0] rdata
);
	logic [7:0] mem [128];
	// Plain always so the bench may preload cells between operations
	assign rdata = mem[addr];
	always @(posedge clk)
		if (we)
			mem[addr] <= wdata;
endmodule
`default_nettype wire

// *** dv/rotate_sub_swap_xor_alu_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module rotate_sub_swap_xor_alu_test;
	import rssx_pkg::*;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [7:0]  reg_rdata, reg_wdata;
	logic [6:0]  reg_addr;
	logic        reg_we;
	int          bad_count = 0;
	int          checked = 0;
	int          cyc = 0;

	rssx_alu dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we));
	rssx_regfile_model pm_u (.clk(aclk), .addr(reg_addr), .wdata(reg_wdata),
		.we(reg_we), .rdata(reg_rdata));

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// About 30 cycles per operation; the ceiling leaves a wide margin
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	initial
	begin
		int op, tg, ad, lit, acc, fl, rv, sb, res, c, dc, z;
		bit          to_reg;
		logic [31:0] d;
		logic [1:0]  r;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} <= '0;
		wstrb <= 4'hf;
		aresetn <= 1'b0;
		void'($urandom(30));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(RSSX_ACC_OFS, d, r);
		chk(d, RSSX_ACC_RST);
		rd(RSSX_FLAGS_OFS, d, r);
		chk(d, RSSX_FLAGS_RST);
		chk(reg_we, 1'b0);
		rd(12'h020, d, r);
		chk(r, RSSX_RESP_SLVERR);
		chk(d, 32'h0);
		wr(12'h020, 32'h5a, r);
		chk(r, RSSX_RESP_SLVERR);
		$display("reset and map test done");
		for (int i = 0; i < 60; i++)
		begin
			op = (i < 12) ? i % 6 + 1 : $urandom_range(6, 1);
			tg = $urandom_range(1);
			ad = (i < 2) ? 127 * (1 - i) : $urandom_range(127);
			acc = $urandom_range(255);
			lit = (i % 5 == 0) ? acc : $urandom_range(255);
			rv = (i % 7 == 0) ? acc : $urandom_range(255);
			fl = $urandom_range(7);
			pm_u.mem[ad] = rv[7:0];
			wr(RSSX_OPER_OFS, lit, r);
			wr(RSSX_ACC_OFS, acc, r);
			wr(RSSX_FLAGS_OFS, fl, r);
			wr(RSSX_CTRL_OFS, ad << 8 | tg << 4 | op, r);
			chk(r, RSSX_RESP_OKAY);
			repeat (4) @(posedge aclk);
			c = fl & 1;
			dc = fl >> 1 & 1;
			z = fl >> 2 & 1;
			res = op == 1 ? c << 7 | rv >> 1 : op == 2 ? lit - acc : op == 3 ? rv - acc :
				op == 4 ? rv << 4 | rv >> 4 : op == 5 ? acc ^ rv : acc ^ lit;
			res &= 255;
			sb = op == 2 ? lit : rv;
			if (op == 1)
				c = rv & 1;
			if (op == 2 || op == 3)
			begin
				c = sb >= acc;
				dc = (sb & 15) >= (acc & 15);
			end
			if (op > 1 && op != 4)
				z = res == 0;
			to_reg = tg == 1 && op != 2 && op != 6;
			rd(RSSX_RESULT_OFS, d, r);
			chk(d, res);
			chk(r, RSSX_RESP_OKAY);
			rd(RSSX_FLAGS_OFS, d, r);
			chk(d, z << 2 | dc << 1 | c);
			rd(RSSX_ACC_OFS, d, r);
			chk(d, to_reg ? acc : res);
			chk(pm_u.mem[ad], to_reg ? res : rv);
		end
		$display("operation test done");
		wr(RSSX_ACC_OFS, 32'h3c, r);
		wr(RSSX_CTRL_OFS, 32'h10, r);
		repeat (4) @(posedge aclk);
		rd(RSSX_ACC_OFS, d, r);
		chk(d, 32'h3c);
		$display("no operation test done");
		end_sim();
	end
endmodule
`default_nettype wire
